// ---- design/sce_state_code_encoder.sv ----
// module: two-wire bus state code encoder with serial event flag
//
// Operation
// (R01) bus error 0x00, idle bus 0xf8
// (R02) master start 0x08, repeated start 0x10
// (R03) master address write: ack 0x18, nack 0x20
// (R04) master data sent: ack 0x28, nack 0x30
// (R05) arbitration lost 0x38; addressed after: 0x68/0xb0/0x78
// (R06) master address read: ack 0x40, nack 0x48
// (R07) master data received: ack 0x50, nack 0x58
// (R08) own address write acknowledged: 0x60
// (R09) general call acknowledged: 0x70
// (R10) own slave data: ack 0x80, nack 0x88
// (R11) general call data: ack 0x90, nack 0x98
// (R12) stop or restart while addressed: 0xa0
// (R13) own address read acknowledged: 0xa8
// (R14) slave sent: 0xb8, 0xc0, last acked 0xc8
// (R15) slave clock-high timeout when enabled: 0xd0
// (R16) code eight bits, low three bits zero
// (R17) software reads code only with flag set
// (R18) code loads with flag, held until change; the idle code 0xf8 loads at a stop without the flag
`timescale 1ns/1ps
module sce_state_code_encoder (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic master_mode_in,
	input wire logic arb_lost_in,
	input wire logic event_clear_in,
	input wire logic acknowledge_setting_in,
	input wire logic general_call_enable_in,
	input wire logic clock_high_timeout_enable_in,
	input wire logic [6:0] own_address_in,
	input wire logic [7:0] clock_rate_setting_in,
	output logic [7:0] bus_state_code_register_out,
	output logic serial_event_flag_out
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// choose the acknowledged or not-acknowledged code
	function automatic logic [7:0] pick(input logic ack, input logic [7:0] a, input logic [7:0] n);
		return ack ? a : n;
	endfunction

	// true while this device is an addressed slave
	function automatic logic is_slave(input sce_pkg::sce_role_t r);
		return (r == sce_pkg::ROLE_SRXO) || (r == sce_pkg::ROLE_SRXG) || (r == sce_pkg::ROLE_STX);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling and bus condition detection

	logic [1:0] pins_s; // synchronised clock and data lines
	logic scl_s; // synchronised clock line
	logic sda_s; // synchronised data line
	logic scl_p_q; // clock line one cycle earlier
	logic sda_p_q; // data line one cycle earlier
	logic tmo; // clock line stayed high too long

	sce_sync #(
		.W(2)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({scl_in, sda_in}),
		.sync_out(pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	sce_tmo u_tmo (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.scl_high_in(scl_s),
		.enable_in(clock_high_timeout_enable_in),
		.rate_in(clock_rate_setting_in),
		.tmo_out(tmo)
	);

	// previous line levels for edge detection
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	logic start_w; // data falls while clock high
	logic stop_w; // data rises while clock high
	logic rise_w; // clock rising edge
	logic fall_w; // clock falling edge that closes a bit slot
	logic rise_seen_q; // a rising edge since the last fall or condition
	logic bit_v_q; // data level sampled at the rising edge
	logic [3:0] cnt_q; // bit slot within the current byte
	logic [7:0] sh_q; // byte shifted in from the bus
	logic byte_done_w; // acknowledge slot has just closed
	logic ack_w; // acknowledge seen in that slot

	assign start_w = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_w = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign rise_w = scl_s && !scl_p_q;
	// the fall right after a start has no rising edge before it and is not a bit
	assign fall_w = !scl_s && scl_p_q && rise_seen_q;
	assign byte_done_w = fall_w && (cnt_q == sce_pkg::BIT_ACK);
	assign ack_w = !bit_v_q;

	// sample data on the rising edge
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			bit_v_q <= 1'b1;
			rise_seen_q <= 1'b0;
		end else begin
			if (rise_w) begin
				bit_v_q <= sda_s;
			end
			if (rise_w) begin
				rise_seen_q <= 1'b1;
			end else if (fall_w || start_w || stop_w) begin
				rise_seen_q <= 1'b0;
			end
		end
	end

	// bits count on the falling edge, so a condition inside a slot is not a bit
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || start_w || stop_w) begin
			cnt_q <= sce_pkg::BIT_ZERO;
		end else if (byte_done_w) begin
			cnt_q <= sce_pkg::BIT_ZERO;
		end else if (fall_w) begin
			cnt_q <= cnt_q + sce_pkg::BIT_ONE;
		end
	end

	// shift register for data slots only
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			sh_q <= '0;
		end else if (fall_w && (cnt_q != sce_pkg::BIT_ACK)) begin
			sh_q <= {sh_q[6:0], bit_v_q};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transfer bookkeeping

	sce_pkg::sce_role_t role_q; // current role on the bus
	sce_pkg::sce_role_t role_d;
	logic busy_q; // a start was seen and no stop since
	logic mstr_q; // this device issued the last start
	logic arb_q; // arbitration lost during the address byte

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			busy_q <= 1'b0;
			mstr_q <= 1'b0;
		end else if (start_w) begin
			busy_q <= 1'b1;
			mstr_q <= master_mode_in;
		end else if (stop_w) begin
			busy_q <= 1'b0;
			mstr_q <= 1'b0;
		end
	end

	// loss during the address byte is held until the acknowledge slot decides
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || start_w || stop_w || byte_done_w) begin
			arb_q <= 1'b0;
		end else if (arb_lost_in && (role_q == sce_pkg::ROLE_ADDR) && mstr_q) begin
			arb_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state code selection; conditions win over bytes, bytes over the timer

	logic ld; // new state reached: load code and raise the flag
	logic idle_ld; // bus went idle: load the idle code quietly
	logic [7:0] ld_code; // code to load
	logic own_m; // address byte names this device
	logic gc_m; // address byte is an enabled general call

	assign own_m = sh_q[7:1] == own_address_in;
	assign gc_m = (sh_q[7:1] == sce_pkg::GC_ADDR) && !sh_q[0] && general_call_enable_in;

	always_comb begin
		ld = 1'b0;
		idle_ld = 1'b0;
		ld_code = bus_state_code_register_out;
		role_d = role_q;
		if (start_w) begin
			role_d = sce_pkg::ROLE_ADDR;
			if (cnt_q != sce_pkg::BIT_ZERO) begin
				ld = 1'b1;
				ld_code = sce_pkg::SC_BUS_ERR; // see R01
				role_d = sce_pkg::ROLE_IDLE;
			end else if (is_slave(role_q)) begin
				ld = 1'b1;
				ld_code = sce_pkg::SC_SLV_STOP; // see R12
			end else if (master_mode_in) begin
				ld = 1'b1;
				ld_code = busy_q ? sce_pkg::SC_RSTART : sce_pkg::SC_START; // see R02
			end
		end else if (stop_w) begin
			role_d = sce_pkg::ROLE_IDLE;
			if (cnt_q != sce_pkg::BIT_ZERO) begin
				ld = 1'b1;
				ld_code = sce_pkg::SC_BUS_ERR; // see R01
			end else if (is_slave(role_q)) begin
				ld = 1'b1;
				ld_code = sce_pkg::SC_SLV_STOP; // see R12
			end else begin
				idle_ld = 1'b1;
				ld_code = sce_pkg::SC_IDLE; // see R01
			end
		end else if (arb_lost_in && ((role_q == sce_pkg::ROLE_MTX) || (role_q == sce_pkg::ROLE_MRX))) begin
			ld = 1'b1;
			ld_code = sce_pkg::SC_ARB_LOST; // see R05
			role_d = sce_pkg::ROLE_IDLE;
		end else if (byte_done_w) begin
			case (role_q)
				sce_pkg::ROLE_ADDR: begin
					role_d = sce_pkg::ROLE_IDLE;
					if (mstr_q && !arb_q) begin
						ld = 1'b1;
						if (sh_q[0]) begin
							role_d = sce_pkg::ROLE_MRX;
							ld_code = pick(ack_w, sce_pkg::SC_MR_AR_ACK, sce_pkg::SC_MR_AR_NACK); // see R06
						end else begin
							role_d = sce_pkg::ROLE_MTX;
							ld_code = pick(ack_w, sce_pkg::SC_MT_AW_ACK, sce_pkg::SC_MT_AW_NACK); // see R03
						end
					end else if (own_m && ack_w) begin
						ld = 1'b1;
						if (sh_q[0]) begin
							role_d = sce_pkg::ROLE_STX;
							ld_code = arb_q ? sce_pkg::SC_ST_OWN_ARB : sce_pkg::SC_ST_OWN; // see R05 R13
						end else begin
							role_d = sce_pkg::ROLE_SRXO;
							ld_code = arb_q ? sce_pkg::SC_SR_OWN_ARB : sce_pkg::SC_SR_OWN; // see R05 R08
						end
					end else if (gc_m && ack_w) begin
						ld = 1'b1;
						role_d = sce_pkg::ROLE_SRXG;
						ld_code = arb_q ? sce_pkg::SC_SR_GC_ARB : sce_pkg::SC_SR_GC; // see R05 R09
					end else if (arb_q) begin
						ld = 1'b1;
						ld_code = sce_pkg::SC_ARB_LOST; // see R05
					end
				end
				sce_pkg::ROLE_MTX: begin
					ld = 1'b1;
					ld_code = pick(ack_w, sce_pkg::SC_MT_D_ACK, sce_pkg::SC_MT_D_NACK); // see R04
				end
				sce_pkg::ROLE_MRX: begin
					ld = 1'b1;
					ld_code = pick(ack_w, sce_pkg::SC_MR_D_ACK, sce_pkg::SC_MR_D_NACK); // see R07
				end
				sce_pkg::ROLE_SRXO: begin
					ld = 1'b1;
					ld_code = pick(ack_w, sce_pkg::SC_SR_OWN_D_ACK, sce_pkg::SC_SR_OWN_D_NACK); // see R10
				end
				sce_pkg::ROLE_SRXG: begin
					ld = 1'b1;
					ld_code = pick(ack_w, sce_pkg::SC_SR_GC_D_ACK, sce_pkg::SC_SR_GC_D_NACK); // see R11
				end
				sce_pkg::ROLE_STX: begin
					ld = 1'b1;
					// a byte sent with the acknowledge setting cleared was meant to be the last
					ld_code = !ack_w ? sce_pkg::SC_ST_D_NACK :
						(acknowledge_setting_in ? sce_pkg::SC_ST_D_ACK : sce_pkg::SC_ST_LAST_ACK); // see R14
				end
				default: begin
					role_d = role_q;
				end
			endcase
		end else if (tmo && is_slave(role_q)) begin
			ld = 1'b1;
			ld_code = sce_pkg::SC_TIMEOUT; // see R15
			role_d = sce_pkg::ROLE_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state registers

	// role follows the selection every cycle
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			role_q <= sce_pkg::ROLE_IDLE;
		end else begin
			role_q <= role_d;
		end
	end

	// code is loaded in the same cycle the flag rises, or quietly with the idle code at a stop, and held otherwise
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			bus_state_code_register_out <= sce_pkg::SC_IDLE;
		end else if (ld || idle_ld) begin
			bus_state_code_register_out <= ld_code; // see R18 R16
		end
	end

	// a new event in the clearing cycle wins so it is never lost
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			serial_event_flag_out <= 1'b0;
		end else if (ld) begin
			serial_event_flag_out <= 1'b1; // see R18
		end else if (event_clear_in) begin
			serial_event_flag_out <= 1'b0; // see R17
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_low_bits_zero;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		serial_event_flag_out |-> (bus_state_code_register_out[2:0] == 3'h0);
	endproperty
	a_low_bits_zero: assert property (p_low_bits_zero) else $error("code low bits nonzero"); // see R16

	property p_load_with_flag;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		ld |=> serial_event_flag_out && (bus_state_code_register_out == $past(ld_code));
	endproperty
	a_load_with_flag: assert property (p_load_with_flag) else $error("code not loaded with flag"); // see R18

	property p_hold;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		!ld && !idle_ld |=> $stable(bus_state_code_register_out);
	endproperty
	a_hold: assert property (p_hold) else $error("code changed without event"); // see R18

	property p_bus_err;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(start_w || stop_w) && (cnt_q != sce_pkg::BIT_ZERO)
			|=> (bus_state_code_register_out == sce_pkg::SC_BUS_ERR) && serial_event_flag_out;
	endproperty
	a_bus_err: assert property (p_bus_err) else $error("bus error not reported"); // see R01

	property p_start;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		start_w && master_mode_in && !busy_q && !is_slave(role_q) && (cnt_q == sce_pkg::BIT_ZERO)
			|=> bus_state_code_register_out == sce_pkg::SC_START;
	endproperty
	a_start: assert property (p_start) else $error("start code wrong"); // see R02

	property p_slave_stop;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		stop_w && is_slave(role_q) && (cnt_q == sce_pkg::BIT_ZERO)
			|=> (bus_state_code_register_out == sce_pkg::SC_SLV_STOP) && (role_q == sce_pkg::ROLE_IDLE);
	endproperty
	a_slave_stop: assert property (p_slave_stop) else $error("slave stop code wrong"); // see R12

	property p_mt_addr;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		byte_done_w && (role_q == sce_pkg::ROLE_ADDR) && mstr_q && !arb_q && !sh_q[0]
			|=> (bus_state_code_register_out == ($past(ack_w) ? sce_pkg::SC_MT_AW_ACK : sce_pkg::SC_MT_AW_NACK))
			&& (role_q == sce_pkg::ROLE_MTX);
	endproperty
	a_mt_addr: assert property (p_mt_addr) else $error("master write address code wrong"); // see R03

	property p_arb;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		arb_lost_in && !start_w && !stop_w && (role_q == sce_pkg::ROLE_MTX)
			|=> (bus_state_code_register_out == sce_pkg::SC_ARB_LOST) && (role_q == sce_pkg::ROLE_IDLE);
	endproperty
	a_arb: assert property (p_arb) else $error("arbitration loss not reported"); // see R05

	property p_st_last;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		byte_done_w && !start_w && !stop_w && (role_q == sce_pkg::ROLE_STX) && ack_w && !acknowledge_setting_in
			|=> bus_state_code_register_out == sce_pkg::SC_ST_LAST_ACK;
	endproperty
	a_st_last: assert property (p_st_last) else $error("last byte code wrong"); // see R14

	property p_timeout;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		tmo && is_slave(role_q) && !start_w && !stop_w && !byte_done_w && !arb_lost_in
			|=> (bus_state_code_register_out == sce_pkg::SC_TIMEOUT) && serial_event_flag_out;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout code wrong"); // see R15

endmodule // sce_state_code_encoder

// ---- design/sce_pkg.sv ----
// package: state codes, role encoding and bit-level constants for the state code encoder
package sce_pkg;

	// reported state codes, all multiples of eight
	localparam logic [7:0] SC_BUS_ERR = 8'h00;
	localparam logic [7:0] SC_START = 8'h08;
	localparam logic [7:0] SC_RSTART = 8'h10;
	localparam logic [7:0] SC_MT_AW_ACK = 8'h18;
	localparam logic [7:0] SC_MT_AW_NACK = 8'h20;
	localparam logic [7:0] SC_MT_D_ACK = 8'h28;
	localparam logic [7:0] SC_MT_D_NACK = 8'h30;
	localparam logic [7:0] SC_ARB_LOST = 8'h38;
	localparam logic [7:0] SC_MR_AR_ACK = 8'h40;
	localparam logic [7:0] SC_MR_AR_NACK = 8'h48;
	localparam logic [7:0] SC_MR_D_ACK = 8'h50;
	localparam logic [7:0] SC_MR_D_NACK = 8'h58;
	localparam logic [7:0] SC_SR_OWN = 8'h60;
	localparam logic [7:0] SC_SR_OWN_ARB = 8'h68;
	localparam logic [7:0] SC_SR_GC = 8'h70;
	localparam logic [7:0] SC_SR_GC_ARB = 8'h78;
	localparam logic [7:0] SC_SR_OWN_D_ACK = 8'h80;
	localparam logic [7:0] SC_SR_OWN_D_NACK = 8'h88;
	localparam logic [7:0] SC_SR_GC_D_ACK = 8'h90;
	localparam logic [7:0] SC_SR_GC_D_NACK = 8'h98;
	localparam logic [7:0] SC_SLV_STOP = 8'ha0;
	localparam logic [7:0] SC_ST_OWN = 8'ha8;
	localparam logic [7:0] SC_ST_OWN_ARB = 8'hb0;
	localparam logic [7:0] SC_ST_D_ACK = 8'hb8;
	localparam logic [7:0] SC_ST_D_NACK = 8'hc0;
	localparam logic [7:0] SC_ST_LAST_ACK = 8'hc8;
	localparam logic [7:0] SC_TIMEOUT = 8'hd0;
	localparam logic [7:0] SC_IDLE = 8'hf8;

	// bit slot counter: slots 0..7 are data, slot 8 is the acknowledge
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// general call address
	localparam logic [6:0] GC_ADDR = 7'h00;

	// clock-high timeout: limit is the inverted rate setting with TMO_SCALE one bits appended below it
	localparam int TMO_SCALE = 4;
	localparam int TMO_W = 8 + TMO_SCALE;

	// bus role of this device, one-hot
	typedef enum logic [6:0] {
		ROLE_IDLE = 7'h01,
		ROLE_ADDR = 7'h02,
		ROLE_MTX = 7'h04,
		ROLE_MRX = 7'h08,
		ROLE_SRXO = 7'h10,
		ROLE_SRXG = 7'h20,
		ROLE_STX = 7'h40
	} sce_role_t;

endpackage

// ---- design/sce_sync.sv ----
// module: two flip-flop synchroniser for the bus pins
`timescale 1ns/1ps
module sce_sync #(
	parameter int W = 2
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// first stage, read only by the second stage
	logic [W-1:0] meta_q;

	////////////////////////////////////////////////////////////////////////////////
	// both stages reset high: an idle two-wire bus floats high
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			meta_q <= '1;
			sync_out <= '1;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // sce_sync

// ---- design/sce_tmo.sv ----
// module: clock line high timer for the slave timeout
`timescale 1ns/1ps
module sce_tmo (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic scl_high_in,
	input wire logic enable_in,
	input wire logic [7:0] rate_in,
	output logic tmo_out
);

	logic [sce_pkg::TMO_W-1:0] cnt_q; // cycles the clock line has stayed high
	logic fired_q; // one pulse per high phase
	logic [sce_pkg::TMO_W-1:0] lim; // limit in system clock cycles

	// a larger rate setting means a shorter allowed high time
	assign lim = {~rate_in, {sce_pkg::TMO_SCALE{1'b1}}};

	////////////////////////////////////////////////////////////////////////////////
	// counter saturates at the limit so a stuck line does not wrap and refire
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || !scl_high_in || !enable_in) begin
			cnt_q <= '0;
		end else if (cnt_q != lim) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// single pulse when the limit is reached
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || !scl_high_in || !enable_in) begin
			tmo_out <= 1'b0;
			fired_q <= 1'b0;
		end else begin
			tmo_out <= (cnt_q == lim) && !fired_q;
			if (cnt_q == lim) begin
				fired_q <= 1'b1;
			end
		end
	end

endmodule // sce_tmo

// ---- tb/sce_bus_model.sv ----
// partner model: the other bus parties driving the two-wire clock and data lines
`timescale 1ns/1ps
module sce_bus_model (
	input wire logic clk_in,
	output logic scl_out,
	output logic sda_out
);
	//////////////////////////////////////////////////////////////////////
	// both lines idle high through their pull-ups
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// wait a number of system clock falls; 4 per clock level gives 200 ns
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// start or repeated start: data falls while the clock is high
	task automatic start();
		if (scl_out == 1'b0) begin
			wt(2);
			sda_out = 1'b1;
			wt(2);
			scl_out = 1'b1;
			wt(4);
		end
		sda_out = 1'b0;
		wt(4);
		scl_out = 1'b0;
	endtask
	// stop: data rises while the clock is high, then the bus is free
	task automatic stop();
		wt(2);
		sda_out = 1'b0;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		sda_out = 1'b1;
		wt(4);
	endtask
	// one bit; data moves mid-low so it never changes beside a clock edge
	task automatic bit_tx(input logic b);
		wt(2);
		sda_out = b;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		scl_out = 1'b0;
	endtask
	// byte msb first, then the acknowledge slot (low = ack), then release
	task automatic byte_tx(input logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_tx(d[i]);
		end
		bit_tx(~ack);
		wt(2);
		sda_out = 1'b1;
	endtask
	// raise the clock and leave it high: a stuck clock for the timer
	task automatic clock_high();
		wt(2);
		scl_out = 1'b1;
	endtask
endmodule // sce_bus_model

// ---- tb/sce_state_code_encoder_tb_top.sv ----
// testbench: state code encoder against a modelled two-wire bus
`timescale 1ns/1ps
module sce_state_code_encoder_tb_top;
	localparam logic [7:0] NONE = 8'h07; // not a code: no event expected
	// ctl bits: master, address ack, data ack, acknowledge setting
	typedef struct packed {
		logic [3:0] ctl;
		logic [7:0] adr;
		logic [7:0] e_st;
		logic [7:0] e_ad;
		logic [7:0] e_da;
		logic [7:0] e_sp;
	} sce_row_t;
	// own address 0x2a (0x54 write, 0x55 read); 0x33 is a foreign target
	sce_row_t rows [14] = '{
		'{4'hf, 8'h66, 8'h08, 8'h18, 8'h28, NONE}, '{4'hd, 8'h66, 8'h08, 8'h18, 8'h30, NONE},
		'{4'h9, 8'h66, 8'h08, 8'h20, NONE, NONE}, '{4'hf, 8'h67, 8'h08, 8'h40, 8'h50, NONE},
		'{4'hd, 8'h67, 8'h08, 8'h40, 8'h58, NONE}, '{4'h9, 8'h67, 8'h08, 8'h48, NONE, NONE},
		'{4'h7, 8'h54, NONE, 8'h60, 8'h80, 8'ha0}, '{4'h5, 8'h54, NONE, 8'h60, 8'h88, 8'ha0},
		'{4'h7, 8'h00, NONE, 8'h70, 8'h90, 8'ha0}, '{4'h5, 8'h00, NONE, 8'h70, 8'h98, 8'ha0},
		'{4'h7, 8'h55, NONE, 8'ha8, 8'hb8, 8'ha0}, '{4'h5, 8'h55, NONE, 8'ha8, 8'hc0, 8'ha0},
		'{4'h6, 8'h55, NONE, 8'ha8, 8'hc8, 8'ha0}, '{4'h7, 8'h66, NONE, NONE, NONE, NONE}};
	// arbitration lost in the address byte: address, code, code at stop
	logic [23:0] arb_tab [4] = '{24'h5468a0, 24'h55b0a0, 24'h0078a0, 24'h663807};
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic scl;
	logic sda;
	logic mm = 1'b0;
	logic arb = 1'b0;
	logic clr = 1'b0;
	logic aa = 1'b1;
	logic tme = 1'b0;
	logic gce = 1'b1; // general call recognition
	logic [7:0] rate = 8'h00;
	logic [7:0] code;
	logic flag;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	//////////////////////////////////////////////////////////////////////
	sce_state_code_encoder u_sce_state_code_encoder (
		.sys_clk_in(sys_clk),
		.sys_rst_in(sys_rst),
		.scl_in(scl),
		.sda_in(sda),
		.master_mode_in(mm),
		.arb_lost_in(arb),
		.event_clear_in(clr),
		.acknowledge_setting_in(aa),
		.general_call_enable_in(gce),
		.clock_high_timeout_enable_in(tme),
		.own_address_in(7'h2a),
		.clock_rate_setting_in(rate),
		.bus_state_code_register_out(code),
		.serial_event_flag_out(flag)
	);
	sce_bus_model u_sce_bus_model (
		.clk_in(sys_clk),
		.scl_out(scl),
		.sda_out(sda)
	);
	//////////////////////////////////////////////////////////////////////
	// 50 ns system clock
	always #25 sys_clk = ~sys_clk;
	// hang guard: the whole run needs well under 10000 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			report_error("run did not finish");
			finish_test();
		end
	end
	// count and print one mismatch
	task automatic report_error(input string msg);
		n_errors++;
		$display("ERROR %0t ns: %s, code %h flag %b", $time, msg, code, flag);
	endtask
	// code is read only while the flag is up, then cleared; code must hold
	task automatic check(input logic [7:0] exp);
		repeat (4) @(negedge sys_clk);
		n_compared++;
		if (exp == NONE) begin
			if (flag !== 1'b0) report_error("flag raised with no event");
		end else begin
			if (code !== exp || flag !== 1'b1) report_error("wrong code or flag");
			clr = 1'b1;
			@(negedge sys_clk);
			clr = 1'b0;
			@(negedge sys_clk);
			n_compared++;
			if (code !== exp || flag !== 1'b0) report_error("code not held or flag stuck");
		end
	endtask
	// verdict
	task automatic finish_test();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	// main sequence: reset, table of plain transfers, then awkward cases
	initial begin
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		n_compared++;
		if (code !== 8'hf8 || flag !== 1'b0) report_error("reset state");
		for (int i = 0; i < 14; i++) begin
			mm = rows[i].ctl[3];
			aa = rows[i].ctl[0];
			u_sce_bus_model.start();
			check(rows[i].e_st);
			u_sce_bus_model.byte_tx(rows[i].adr, rows[i].ctl[2]);
			check(rows[i].e_ad);
			if (rows[i].e_da != NONE) begin
				u_sce_bus_model.byte_tx(8'h3c, rows[i].ctl[1]);
				check(rows[i].e_da);
			end
			u_sce_bus_model.stop();
			check(rows[i].e_sp);
		end
		aa = 1'b1;
		// master repeated start
		mm = 1'b1;
		u_sce_bus_model.start();
		check(8'h08);
		u_sce_bus_model.byte_tx(8'h66, 1'b1);
		check(8'h18);
		u_sce_bus_model.start();
		check(8'h10);
		// arbitration lost in the data phase
		u_sce_bus_model.byte_tx(8'h66, 1'b1);
		check(8'h18);
		arb = 1'b1;
		@(negedge sys_clk);
		arb = 1'b0;
		check(8'h38);
		u_sce_bus_model.stop();
		check(NONE);
		// arbitration lost in the address byte, then addressed or not
		for (int i = 0; i < 4; i++) begin
			mm = 1'b1;
			u_sce_bus_model.start();
			check(8'h08);
			arb = 1'b1;
			@(negedge sys_clk);
			arb = 1'b0;
			u_sce_bus_model.byte_tx(arb_tab[i][23:16], 1'b1);
			check(arb_tab[i][15:8]);
			u_sce_bus_model.stop();
			check(arb_tab[i][7:0]);
		end
		// repeated start while addressed as a slave
		mm = 1'b0;
		u_sce_bus_model.start();
		check(NONE);
		u_sce_bus_model.byte_tx(8'h54, 1'b1);
		check(8'h60);
		u_sce_bus_model.start();
		check(8'ha0);
		u_sce_bus_model.byte_tx(8'h66, 1'b1);
		check(NONE);
		u_sce_bus_model.stop();
		check(NONE);
		// stop in the middle of a byte is a bus error
		u_sce_bus_model.start();
		u_sce_bus_model.bit_tx(1'b1);
		u_sce_bus_model.bit_tx(1'b0);
		u_sce_bus_model.bit_tx(1'b1);
		u_sce_bus_model.stop();
		check(8'h00);
		// start in the middle of a byte is a bus error too
		u_sce_bus_model.start();
		u_sce_bus_model.bit_tx(1'b0);
		u_sce_bus_model.bit_tx(1'b1);
		u_sce_bus_model.start();
		check(8'h00);
		u_sce_bus_model.stop();
		check(NONE);
		// general call ignored while recognition is off
		gce = 1'b0;
		u_sce_bus_model.start();
		u_sce_bus_model.byte_tx(8'h00, 1'b1);
		check(NONE);
		u_sce_bus_model.stop();
		check(NONE);
		gce = 1'b1;
		// stuck-high clock while slave with the timer enabled
		u_sce_bus_model.start();
		check(NONE);
		u_sce_bus_model.byte_tx(8'h54, 1'b1);
		check(8'h60);
		tme = 1'b1;
		rate = 8'hff;
		u_sce_bus_model.clock_high();
		repeat (30) @(negedge sys_clk);
		check(8'hd0);
		tme = 1'b0;
		rate = 8'h00;
		u_sce_bus_model.start();
		u_sce_bus_model.stop();
		check(NONE);
		finish_test();
	end
endmodule // sce_state_code_encoder_tb_top
